// ### design/rsc_low_filter.sv
// Minimum width filter for the low supply indication, timed in slow RC ticks.
`timescale 1ns/1ps
`include "rsc_params.svh"
module rsc_low_filter
  import rsc_pkg::*;
(
  input wire logic sys_clk, // System clock.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic enable, // Low supply reset armed.
  input wire logic supply_low, // Supply below the selected threshold.
  input wire logic tick, // One pulse per slow RC period.
  input wire logic [1:0] width_code, // Minimum width selector.
  output logic fire // One-cycle pulse when the dip lasted long enough.
);

  logic [7:0] ticks;
  logic [7:0] limit;

  always_comb begin
    unique case (width_code)
      2'b00: limit = `RSC_TICKS_W0;
      2'b01: limit = `RSC_TICKS_W1;
      2'b10: limit = `RSC_TICKS_W2;
      2'b11: limit = `RSC_TICKS_W3;
    endcase
  end

  // A dip that ends or is disarmed restarts the count, so short dips never fire.
  always_ff @(posedge sys_clk) begin
    if (rst || !enable || !supply_low) begin
      ticks <= 8'h00;
      fire <= 1'b0;
    end else if (tick && ticks != limit) begin
      ticks <= ticks + 8'h01;
      fire <= (ticks + 8'h01) == limit;
    end else begin
      fire <= 1'b0;
    end
  end

  property p_fire_needs_low;
    @(posedge sys_clk) disable iff (rst) fire |-> $past(supply_low) && $past(enable);
  endproperty
  a_fire_needs_low: assert property (p_fire_needs_low) else $error("low reset without dip");

endmodule

// ### design/rsc_params.svh
// Register map, codes, reset values and timing figures of the reset source block.
`ifndef RSC_PARAMS_SVH
`define RSC_PARAMS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define RSC_ADDR_KEY 4'h0
`define RSC_ADDR_CAUSE 4'h4
`define RSC_ADDR_LEVEL 4'h8
`define RSC_ADDR_WIDTH 4'hC

// ----------------------------------------------------------------------
// Codes and reset values
// ----------------------------------------------------------------------
`define RSC_KEY_GPIO 8'h55
`define RSC_KEY_PIN 8'hAA
`define RSC_LVL_1V70 8'h66
`define RSC_LVL_1V90 8'h55
`define RSC_LVL_2V55 8'h33
`define RSC_LVL_3V15 8'h99
`define RSC_LVL_3V80 8'hAA
`define RSC_LVL_OFF 8'hF0
`define RSC_WIDTH_POR 2'h1
`define RSC_CAUSE_POR 4'h0

// ----------------------------------------------------------------------
// Cause flag bit positions
// ----------------------------------------------------------------------
`define RSC_BIT_KEYSW 3
`define RSC_BIT_LOW 2
`define RSC_BIT_LVLSW 1
`define RSC_BIT_DOG 0

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define RSC_CLK_HZ 100000000
`define RSC_LIRC_HZ 32000
`define RSC_LIRC_DIV (`RSC_CLK_HZ / `RSC_LIRC_HZ)
`define RSC_SRESET_NS 20000
`define RSC_RSTD_NS 100000
`define RSC_TICKS_W0 8'd8
`define RSC_TICKS_W1 8'd32
`define RSC_TICKS_W2 8'd64
`define RSC_TICKS_W3 8'd128

`endif

// ### design/rsc_pin_sync.sv
// Reset pin synchroniser with falling edge detector.
`timescale 1ns/1ps
`include "rsc_params.svh"
module rsc_pin_sync
  import rsc_pkg::*;
(
  input wire logic sys_clk, // System clock.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic pin_in, // Raw reset pin level.
  output logic pin_level, // Synchronised pin level.
  output logic pin_fall // One-cycle pulse on a high to low change.
);

  logic meta;
  logic sync;
  logic last;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      meta <= 1'b1;
      sync <= 1'b1;
      last <= 1'b1;
    end else begin
      meta <= pin_in;
      sync <= meta;
      last <= sync;
    end
  end

  assign pin_level = sync;
  assign pin_fall = last & ~sync;

endmodule

// ### design/rsc_pkg.sv
// Types shared by the reset source block.
package rsc_pkg;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_SWDLY = 2'b01,
    ST_HOLD = 2'b10,
    ST_START = 2'b11
  } rsc_state_e;

  typedef enum logic [1:0] {
    K_PIN = 2'b00,
    K_KEY = 2'b01,
    K_LEVEL = 2'b10,
    K_LOW = 2'b11
  } rsc_kind_e;

  typedef struct packed {
    logic core_hold;
    logic run_start;
  } rsc_core_ctl_s;

  typedef struct packed {
    logic armed;
    logic [2:0] level_index;
  } rsc_lvr_ctl_s;

endpackage

// ### design/rsc_top.sv
// Reset source control: reset pin, key register, low supply reset and cause flags.
`timescale 1ns/1ps
`include "rsc_params.svh"

// Notes on behaviour
// - Power-on reset holds the core so execution restarts at address zero.
// - Power-on reset presets all port data and direction registers to ones.
// - With pin function selected, a pin falling edge resets the core.
// - After reset release, a start-up delay passes before execution resumes.
// - Key 55h routes the pin to I/O; AAh routes it to reset.
// - Any other key value resets the device after the software-reset delay.
// - Key register reloads 55h on power-up and every reset here.
// - Reset pin selection overrides any other pin-sharing control.
// - Bad key reset sets bit 3 flag; only writing zero clears it.
// - Cause flag bits 7 to 4 always read zero.
// - Low supply reset is disabled automatically in SLEEP and IDLE.
// - Low supply resets only after a dip longer than the minimum width.
// - Width codes 00 to 11 select 8, 32, 64, 128 slow RC periods.
// - Five level codes pick thresholds; F0h disables low supply reset.
// - Other level codes reset after delay, set flag, reload power-on value.
// - Level register loads 66h on power-up.
// - A real low supply reset keeps the level register unchanged.
// - Low supply reset sets its flag; only writing zero clears it.
module rsc_top
  import rsc_pkg::*;
#(
  parameter int SRESET_NS = `RSC_SRESET_NS,
  parameter int RSTD_NS = `RSC_RSTD_NS
) (
  input wire logic sys_clk, // System clock, 100 MHz.
  input wire logic rst, // Power-on reset, synchronous, active high.
  input wire logic [3:0] avs_address, // Byte address.
  input wire logic avs_read, // Read request.
  input wire logic avs_write, // Write request.
  input wire logic [31:0] avs_writedata, // Write data.
  input wire logic [3:0] avs_byteenable, // Byte lanes.
  output logic [31:0] avs_readdata, // Read data.
  output logic avs_waitrequest, // Stall.
  input wire logic ext_reset_pin, // Shared reset pin level.
  input wire logic supply_low_in, // Monitor: supply below selected level.
  input wire logic low_power_mode, // Core is in SLEEP or IDLE.
  output rsc_core_ctl_s core_ctl, // Core hold and start pulse.
  output logic pin_reset_select, // Pin owned by reset function.
  output rsc_lvr_ctl_s lvr_ctl // Monitor arming and threshold index.
);

  // ----------------------------------------------------------------------
  // Derived cycle counts
  // ----------------------------------------------------------------------
  localparam int CLK_MHZ = `RSC_CLK_HZ / 1000000;
  localparam int SRESET_RAW = (SRESET_NS * CLK_MHZ + 999) / 1000;
  localparam int RSTD_RAW = (RSTD_NS * CLK_MHZ + 999) / 1000;
  localparam int SRESET_CYC = (SRESET_RAW < 1) ? 1 : SRESET_RAW;
  localparam int RSTD_CYC = (RSTD_RAW < 1) ? 1 : RSTD_RAW;
  localparam logic [19:0] SRESET_LAST = 20'(SRESET_CYC - 1);
  localparam logic [19:0] RSTD_LAST = 20'(RSTD_CYC - 1);
  localparam logic [11:0] LIRC_LAST = 12'(`RSC_LIRC_DIV - 1);

  rsc_state_e state;
  rsc_kind_e kind;
  logic [19:0] cnt;
  logic [11:0] div_cnt;
  logic lirc_tick;
  logic [7:0] pin_function_key_reg;
  logic [7:0] supply_level_reg;
  logic [1:0] supply_width_reg;
  logic [3:0] cause_flag_reg;
  logic pin_level;
  logic pin_fall;
  logic lvr_fire;
  logic lvr_en;
  logic key_bad;
  logic level_bad;
  logic level_off;
  logic [2:0] level_index;
  logic pin_trig;
  logic wr_ok;
  logic sw_fire;
  logic [3:0] next_cause;

  // ----------------------------------------------------------------------
  // Pin synchroniser and slow tick
  // ----------------------------------------------------------------------
  rsc_pin_sync u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .pin_in(ext_reset_pin),
    .pin_level(pin_level),
    .pin_fall(pin_fall)
  );

  always_ff @(posedge sys_clk) begin
    if (rst || div_cnt == LIRC_LAST) begin
      div_cnt <= 12'h000;
    end else begin
      div_cnt <= div_cnt + 12'h001;
    end
  end

  assign lirc_tick = (div_cnt == LIRC_LAST);

  // ----------------------------------------------------------------------
  // Code decode
  // ----------------------------------------------------------------------
  always_comb begin
    level_bad = 1'b0;
    level_off = 1'b0;
    level_index = 3'h0;
    unique case (supply_level_reg)
      `RSC_LVL_1V70: level_index = 3'h0;
      `RSC_LVL_1V90: level_index = 3'h1;
      `RSC_LVL_2V55: level_index = 3'h2;
      `RSC_LVL_3V15: level_index = 3'h3;
      `RSC_LVL_3V80: level_index = 3'h4;
      `RSC_LVL_OFF: level_off = 1'b1;
      default: level_bad = 1'b1;
    endcase
  end

  assign key_bad = pin_function_key_reg != `RSC_KEY_GPIO &&
                   pin_function_key_reg != `RSC_KEY_PIN;
  assign lvr_en = !level_bad && !level_off && !low_power_mode && state == ST_RUN;
  assign pin_trig = pin_fall && pin_function_key_reg == `RSC_KEY_PIN;
  assign sw_fire = state == ST_SWDLY && cnt == SRESET_LAST;

  rsc_low_filter u_filter (
    .sys_clk(sys_clk),
    .rst(rst),
    .enable(lvr_en),
    .supply_low(supply_low_in),
    .tick(lirc_tick),
    .width_code(supply_width_reg),
    .fire(lvr_fire)
  );

  // ----------------------------------------------------------------------
  // Reset sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= ST_START;
      kind <= K_PIN;
      cnt <= 20'h00000;
    end else begin
      unique case (state)
        ST_RUN: begin
          cnt <= 20'h00000;
          if (lvr_fire) begin
            state <= ST_HOLD;
            kind <= K_LOW;
          end else if (pin_trig) begin
            state <= ST_HOLD;
            kind <= K_PIN;
          end else if (key_bad) begin
            state <= ST_SWDLY;
            kind <= K_KEY;
          end else if (level_bad) begin
            state <= ST_SWDLY;
            kind <= K_LEVEL;
          end
        end
        ST_SWDLY: begin
          if (sw_fire) begin
            state <= ST_START;
            cnt <= 20'h00000;
          end else begin
            cnt <= cnt + 20'h00001;
          end
        end
        ST_HOLD: begin
          cnt <= 20'h00000;
          if ((kind == K_PIN && pin_level) || (kind == K_LOW && !supply_low_in)) begin
            state <= ST_START;
          end
        end
        ST_START: begin
          if (cnt == RSTD_LAST) begin
            state <= ST_RUN;
            cnt <= 20'h00000;
          end else begin
            cnt <= cnt + 20'h00001;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Core and monitor controls
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      core_ctl <= '{core_hold: 1'b1, run_start: 1'b0};
      pin_reset_select <= 1'b0;
      lvr_ctl <= '{armed: 1'b0, level_index: 3'h0};
    end else begin
      core_ctl.core_hold <= state != ST_RUN;
      core_ctl.run_start <= state == ST_START && cnt == RSTD_LAST;
      pin_reset_select <= pin_function_key_reg == `RSC_KEY_PIN;
      // The monitor stays armed through a low supply hold, so the reset lasts as long as the dip.
      lvr_ctl <= '{armed: lvr_en || (state == ST_HOLD && kind == K_LOW && !low_power_mode),
                   level_index: level_index};
    end
  end

  // ----------------------------------------------------------------------
  // Registers and bus slave
  // ----------------------------------------------------------------------
  assign wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];

  always_ff @(posedge sys_clk) begin
    if (rst || (state == ST_RUN && (lvr_fire || pin_trig)) || sw_fire) begin
      pin_function_key_reg <= `RSC_KEY_GPIO;
    end else if (wr_ok && avs_address == `RSC_ADDR_KEY && state == ST_RUN) begin
      pin_function_key_reg <= avs_writedata[7:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst || (state == ST_RUN && pin_trig && !lvr_fire) || sw_fire) begin
      supply_level_reg <= `RSC_LVL_1V70;
      supply_width_reg <= `RSC_WIDTH_POR;
    end else if (wr_ok && state == ST_RUN) begin
      if (avs_address == `RSC_ADDR_LEVEL) begin
        supply_level_reg <= avs_writedata[7:0];
      end
      if (avs_address == `RSC_ADDR_WIDTH) begin
        supply_width_reg <= avs_writedata[1:0];
      end
    end
  end

  // Flags are only cleared by a written zero; a same-cycle set wins.
  always_comb begin
    next_cause = cause_flag_reg;
    if (wr_ok && avs_address == `RSC_ADDR_CAUSE) begin
      next_cause = cause_flag_reg & avs_writedata[3:0];
    end
    next_cause[`RSC_BIT_KEYSW] = next_cause[`RSC_BIT_KEYSW] | (sw_fire && kind == K_KEY);
    next_cause[`RSC_BIT_LVLSW] = next_cause[`RSC_BIT_LVLSW] | (sw_fire && kind == K_LEVEL);
    next_cause[`RSC_BIT_LOW] = next_cause[`RSC_BIT_LOW] | (state == ST_RUN && lvr_fire);
    next_cause[`RSC_BIT_DOG] = 1'b0;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cause_flag_reg <= `RSC_CAUSE_POR;
    end else begin
      cause_flag_reg <= next_cause;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else if (!avs_waitrequest) begin
      avs_waitrequest <= 1'b1;
    end else if (avs_read || avs_write) begin
      avs_waitrequest <= 1'b0;
      avs_readdata <= 32'h00000000;
      if (avs_read) begin
        unique case (avs_address)
          `RSC_ADDR_KEY: avs_readdata <= {24'h000000, pin_function_key_reg};
          `RSC_ADDR_CAUSE: avs_readdata <= {28'h0000000, cause_flag_reg};
          `RSC_ADDR_LEVEL: avs_readdata <= {24'h000000, supply_level_reg};
          `RSC_ADDR_WIDTH: avs_readdata <= {30'h0, supply_width_reg};
          default: avs_readdata <= 32'h00000000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_hold_core;
    (state == ST_HOLD) |=> core_ctl.core_hold;
  endproperty
  a_hold_core: assert property (p_hold_core) else $error("core not held");

  property p_pin_reset;
    (state == ST_RUN && pin_trig && !lvr_fire) |=> state == ST_HOLD && kind == K_PIN;
  endproperty
  a_pin_reset: assert property (p_pin_reset) else $error("pin reset missed");

  property p_startup;
    (state == ST_START && cnt != RSTD_LAST) |=> state == ST_START && core_ctl.core_hold;
  endproperty
  a_startup: assert property (p_startup) else $error("start-up delay cut short");

  property p_key_bad;
    (state == ST_RUN && key_bad && !lvr_fire && !pin_trig) |=> state == ST_SWDLY;
  endproperty
  a_key_bad: assert property (p_key_bad) else $error("bad key ignored");

  property p_key_flag;
    (sw_fire && kind == K_KEY) |=>
      cause_flag_reg[`RSC_BIT_KEYSW] && pin_function_key_reg == `RSC_KEY_GPIO;
  endproperty
  a_key_flag: assert property (p_key_flag) else $error("key reset flag or reload wrong");

  property p_high_zero;
    (avs_read && avs_waitrequest && avs_address == `RSC_ADDR_CAUSE) |=>
      avs_readdata[31:4] == 28'h0000000 && !avs_waitrequest;
  endproperty
  a_high_zero: assert property (p_high_zero) else $error("flag upper bits not zero");

  property p_lowpower;
    low_power_mode |=> !lvr_fire;
  endproperty
  a_lowpower: assert property (p_lowpower) else $error("low reset in low power");

  property p_level_bad;
    (sw_fire && kind == K_LEVEL) |=>
      cause_flag_reg[`RSC_BIT_LVLSW] && supply_level_reg == `RSC_LVL_1V70;
  endproperty
  a_level_bad: assert property (p_level_bad) else $error("level reset wrong");

  property p_level_kept;
    (state == ST_RUN && lvr_fire) |=>
      supply_level_reg == $past(supply_level_reg) && cause_flag_reg[`RSC_BIT_LOW];
  endproperty
  a_level_kept: assert property (p_level_kept) else $error("low reset lost level");

  c_pin_reset: cover property (state == ST_HOLD && kind == K_PIN);
  c_low_reset: cover property (state == ST_HOLD && kind == K_LOW);
  c_key_reset: cover property (sw_fire && kind == K_KEY);
  c_level_reset: cover property (sw_fire && kind == K_LEVEL);

endmodule

// ### verif/rsc_far_side.sv
// Model of the external reset network and the supply monitor.
`timescale 1ns/1ps
module rsc_far_side
  import rsc_pkg::*;
#(
  parameter int RISE = 4
) (
  input wire logic sys_clk, // System clock.
  input wire logic press, // Bench holds the reset button.
  input wire logic dip, // Bench pulls the supply below the threshold.
  input wire rsc_lvr_ctl_s lvr_ctl, // Monitor arming from the block.
  output logic ext_reset_pin, // Pin level, pulled up when released.
  output logic supply_low_in // Monitor comparator output.
);
  // ----------------------------------------------------------------------
  // Reset network
  // ----------------------------------------------------------------------
  int rise_cnt = 0;

  // The capacitor keeps the pin low for RISE cycles after the button opens.
  always_ff @(posedge sys_clk) begin
    if (press) begin
      rise_cnt <= RISE;
    end else if (rise_cnt > 0) begin
      rise_cnt <= rise_cnt - 1;
    end
  end

  assign ext_reset_pin = !(press || rise_cnt > 0);

  // ----------------------------------------------------------------------
  // Supply monitor
  // ----------------------------------------------------------------------
  // A disarmed comparator reports a good supply.
  assign supply_low_in = dip && lvr_ctl.armed;
endmodule

// ### verif/rsc_top_bench.sv
// Self-checking bench for the reset source block.
`timescale 1ns/1ps
`include "rsc_params.svh"
module rsc_top_bench
  import rsc_pkg::*;
;
  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic ext_reset_pin;
  logic supply_low_in;
  logic low_power_mode = 1'b0;
  logic press = 1'b0;
  logic dip = 1'b0;
  rsc_core_ctl_s core_ctl;
  logic pin_reset_select;
  rsc_lvr_ctl_s lvr_ctl;
  int n_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  int n;
  logic [31:0] d;
  logic [7:0] lvl [5] = '{`RSC_LVL_1V70, `RSC_LVL_1V90, `RSC_LVL_2V55, `RSC_LVL_3V15,
    `RSC_LVL_3V80};

  always #5 sys_clk = ~sys_clk;

  rsc_top #(.SRESET_NS(100), .RSTD_NS(200)) DUT (
    .sys_clk(sys_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .ext_reset_pin(ext_reset_pin), .supply_low_in(supply_low_in),
    .low_power_mode(low_power_mode), .core_ctl(core_ctl),
    .pin_reset_select(pin_reset_select), .lvr_ctl(lvr_ctl));

  rsc_far_side #(.RISE(4)) FAR (
    .sys_clk(sys_clk), .press(press), .dip(dip), .lvr_ctl(lvr_ctl),
    .ext_reset_pin(ext_reset_pin), .supply_low_in(supply_low_in));

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic stop_test();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One Avalon access; the request stands until waitrequest is sampled low.
  // The slave answers one cycle after it sees the request, so k ends at 2.
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] wd,
    input logic [3:0] be, output logic [31:0] rd);
    int k;
    k = 0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= {24'h0, wd};
    avs_byteenable <= be;
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge sys_clk);
      k++;
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    chk("bus_latency", 32'h2, k);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] wd);
    logic [31:0] t;
    bus(1'b1, a, wd, 4'h1, t);
  endtask

  task automatic rd_chk(input string what, input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] t;
    bus(1'b0, a, 8'h0, 4'hF, t);
    chk(what, exp, t);
  endtask

  task automatic wait_hold(input logic v, input int lim, output int cnt);
    cnt = 0;
    while (core_ctl.core_hold !== v && cnt < lim) begin
      @(posedge sys_clk);
      cnt++;
    end
  endtask

  // Counts cycles to the start pulse, then waits for the core to run.
  task automatic resume(input string what, input int lo);
    int c;
    c = 0;
    do begin
      @(posedge sys_clk);
      c++;
    end while (core_ctl.run_start !== 1'b1 && c < 200);
    chk(what, 32'h1, c >= lo - 1 && c <= lo + 8);
    wait_hold(1'b0, 4, c);
    chk("core_hold", 32'h0, core_ctl.core_hold);
  endtask

  // ----------------------------------------------------------------------
  // Timeout
  // ----------------------------------------------------------------------
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_errors++;
      stop_test();
    end
  end

  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    chk("core_hold", 32'h1, core_ctl.core_hold);
    resume("startup", 20);
    rd_chk("key", `RSC_ADDR_KEY, 32'h55);
    rd_chk("level", `RSC_ADDR_LEVEL, 32'h66);
    rd_chk("width", `RSC_ADDR_WIDTH, 32'h1);
    rd_chk("cause", `RSC_ADDR_CAUSE, 32'h0);
    rd_chk("unmapped", 4'h2, 32'h0);
    bus(1'b1, `RSC_ADDR_KEY, 8'h12, 4'h0, d);
    rd_chk("key", `RSC_ADDR_KEY, 32'h55);
    // The pin is ignored while it serves as I/O.
    press <= 1'b1;
    repeat (10) @(posedge sys_clk);
    chk("core_hold", 32'h0, core_ctl.core_hold);
    press <= 1'b0;
    repeat (10) @(posedge sys_clk);
    wr(`RSC_ADDR_KEY, `RSC_KEY_PIN);
    rd_chk("key", `RSC_ADDR_KEY, 32'hAA);
    chk("pin_reset_select", 32'h1, pin_reset_select);
    press <= 1'b1;
    wait_hold(1'b1, 10, n);
    chk("core_hold", 32'h1, core_ctl.core_hold);
    repeat (5) @(posedge sys_clk);
    press <= 1'b0;
    resume("startup", 27);
    rd_chk("key", `RSC_ADDR_KEY, 32'h55);
    chk("pin_reset_select", 32'h0, pin_reset_select);
    // A corrupted key resets after the software delay and start-up delay.
    wr(`RSC_ADDR_KEY, 8'h12);
    resume("swreset", 30);
    rd_chk("cause", `RSC_ADDR_CAUSE, 32'h8);
    rd_chk("key", `RSC_ADDR_KEY, 32'h55);
    wr(`RSC_ADDR_CAUSE, 8'h0F);
    rd_chk("cause", `RSC_ADDR_CAUSE, 32'h8);
    wr(`RSC_ADDR_CAUSE, 8'h00);
    rd_chk("cause", `RSC_ADDR_CAUSE, 32'h0);
    for (int i = 0; i < 5; i++) begin
      wr(`RSC_ADDR_LEVEL, lvl[i]);
      rd_chk("level", `RSC_ADDR_LEVEL, {24'h0, lvl[i]});
      chk("level_index", i, lvr_ctl.level_index);
      chk("armed", 32'h1, lvr_ctl.armed);
    end
    wr(`RSC_ADDR_LEVEL, `RSC_LVL_OFF);
    rd_chk("level", `RSC_ADDR_LEVEL, 32'hF0);
    chk("armed", 32'h0, lvr_ctl.armed);
    wr(`RSC_ADDR_LEVEL, `RSC_LVL_2V55);
    low_power_mode <= 1'b1;
    rd_chk("level", `RSC_ADDR_LEVEL, 32'h33);
    chk("armed", 32'h0, lvr_ctl.armed);
    low_power_mode <= 1'b0;
    // A corrupted level code resets and reloads the power-on level.
    wr(`RSC_ADDR_LEVEL, 8'h77);
    resume("swreset", 30);
    rd_chk("cause", `RSC_ADDR_CAUSE, 32'h2);
    rd_chk("level", `RSC_ADDR_LEVEL, 32'h66);
    wr(`RSC_ADDR_CAUSE, 8'h00);
    // Low supply: a short dip is filtered, a long one resets.
    wr(`RSC_ADDR_LEVEL, `RSC_LVL_2V55);
    wr(`RSC_ADDR_WIDTH, 8'h00);
    dip <= 1'b1;
    repeat (6 * 3125) @(posedge sys_clk);
    dip <= 1'b0;
    chk("core_hold", 32'h0, core_ctl.core_hold);
    repeat (10) @(posedge sys_clk);
    dip <= 1'b1;
    wait_hold(1'b1, 10 * 3125, n);
    chk("core_hold", 32'h1, core_ctl.core_hold);
    chk("low_width", 32'h1, n >= 7 * 3125 - 1 && n <= 8 * 3125 + 10);
    repeat (20) @(posedge sys_clk);
    chk("core_hold", 32'h1, core_ctl.core_hold);
    dip <= 1'b0;
    resume("startup", 20);
    rd_chk("cause", `RSC_ADDR_CAUSE, 32'h4);
    rd_chk("level", `RSC_ADDR_LEVEL, 32'h33);
    rd_chk("width", `RSC_ADDR_WIDTH, 32'h0);
    wr(`RSC_ADDR_CAUSE, 8'h00);
    rd_chk("cause", `RSC_ADDR_CAUSE, 32'h0);
    stop_test();
  end
endmodule
